// *** shared/dhw_pkg.sv ***
// Shared constants and types for the DAC host write control block.
package dhw_pkg;
  // Clock rate and timing figures.
  localparam int CLK_HZ = 20_000_000;
  localparam int POR_TIME_MS = 8;
  localparam int POR_CYC = POR_TIME_MS * (CLK_HZ / 1000);
  localparam int RST_MIN_US = 70;
  localparam int RST_CYC = (RST_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int CNT_W = 18;
  // Sizes.
  localparam int NUM_CH = 32;
  localparam int DATA_W = 14;
  localparam int ADDR_W = 8;
  localparam int CMD_W = 24;
  localparam int FIFO_DEPTH = 120;
  localparam int PTR_W = 7;
  // Command word field positions.
  localparam int CMD_DHI_BIT = 23;
  localparam int CMD_DLO_BIT = 22;
  localparam int CMD_ADDR_LSB = 14;
  localparam int STEP_DIR_BIT = 8;
  localparam int STEP_W = 7;
  localparam logic [4:0] SER_BITS = 5'h18;
  // Destination select codes.
  localparam logic [1:0] DEST_INPUT = 2'h3;
  localparam logic [1:0] DEST_OFFSET = 2'h2;
  localparam logic [1:0] DEST_GAIN = 2'h1;
  localparam logic [1:0] DEST_SPECIAL = 2'h0;
  // Data codes and register defaults.
  localparam logic [13:0] SOFT_RESET_CODE = 14'h3fff;
  localparam logic [13:0] FULL_SCALE = 14'h3fff;
  localparam logic [13:0] ZERO_SCALE = 14'h0000;
  localparam logic [13:0] INPUT_DEF = 14'h0000;
  localparam logic [13:0] OFFSET_DEF = 14'h2000;
  localparam logic [13:0] GAIN_DEF = 14'h3fff;
  // Common types.
  typedef logic [13:0] dhw_word_t;
  typedef logic [23:0] dhw_cmd_t;
  typedef enum logic [3:0] {
    ST_POR = 4'h1,
    ST_RST = 4'h2,
    ST_IDLE = 4'h4,
    ST_EXEC = 4'h8
  } dhw_state_t;
endpackage

// *** shared/dhw_cmd_if.sv ***
// Command queue handshake between the write control and its command FIFO.
`timescale 1ns/10ps
`default_nettype none
interface dhw_cmd_if;
  logic push_valid;
  logic push_ready;
  dhw_pkg::dhw_cmd_t push_data;
  logic pop_valid;
  logic pop_ready;
  dhw_pkg::dhw_cmd_t pop_data;
  // The queue side takes pushes and offers pops.
  modport queue (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  // The user side pushes decoded writes and pops commands to execute.
  modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// *** rtl/dhw_cmd_fifo.sv ***
// Command FIFO holding queued write commands.
`timescale 1ns/10ps
`default_nettype none
module dhw_cmd_fifo
  import dhw_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Push and pop handshake.
  dhw_cmd_if.queue q
);
  // Pointer and fill state.
  typedef struct packed {
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [PTR_W-1:0] cnt;
  } dhw_fifo_regs_t;

  dhw_fifo_regs_t r_q, r_d; // Registered state and its next value.
  dhw_cmd_t mem [FIFO_DEPTH]; // Command storage.
  logic do_push; // A push is taken this cycle.
  logic do_pop; // A pop is taken this cycle.

  // Pointers wrap at the last slot, since the depth is not a power of two.
  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    next_ptr = (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Full and empty come straight from the fill count.
  assign q.push_ready = (r_q.cnt != PTR_W'(FIFO_DEPTH));
  assign q.pop_valid = (r_q.cnt != '0);
  assign q.pop_data = mem[r_q.rd];
  assign do_push = q.push_valid & q.push_ready; // Writes into a full queue are lost.
  assign do_pop = q.pop_valid & q.pop_ready;

  // Next pointer and count.
  always_comb begin
    r_d = r_q;
    if (do_push) begin
      r_d.wr = next_ptr(r_q.wr);
    end
    if (do_pop) begin
      r_d.rd = next_ptr(r_q.rd);
    end
    r_d.cnt = r_q.cnt + PTR_W'(do_push) - PTR_W'(do_pop);
  end

  // State register.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Storage write, kept apart from the control state.
  always_ff @(posedge mclk_i) begin
    if (do_push) begin
      mem[r_q.wr] <= q.push_data;
    end
  end
endmodule
`default_nettype wire

// *** rtl/dhw_top.sv ***
// Write side control of a 32 channel DAC: parallel and serial command intake and execution.
`timescale 1ns/10ps
`default_nettype none
module dhw_top
  import dhw_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC // Power-on sequence length in clock cycles.
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Control pins.
  input wire logic reset_pin_n_i,
  input wire logic output_clear_n_i,
  input wire logic load_outputs_n_i,
  input wire logic interface_select_i,
  // Shared busy line.
  input wire logic busy_i,
  output logic busy_o,
  output logic busy_oe_o,
  // Parallel bus.
  input wire logic chip_select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic dest_select_hi_i,
  input wire logic dest_select_lo_i,
  input wire logic [ADDR_W-1:0] channel_address_i,
  input wire logic [DATA_W-1:0] data_word_i,
  // Serial link.
  input wire logic serial_clock_i,
  input wire logic frame_sync_n_i,
  input wire logic serial_in_i,
  input wire logic chain_enable_i,
  output logic serial_out_o,
  // Output side.
  output logic outputs_grounded_o,
  output logic [NUM_CH-1:0][DATA_W-1:0] dac_value_o
);
  // All state of the block.
  typedef struct packed {
    dhw_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [4:0] ch;
    dhw_cmd_t cur;
    logic [2:0] sclk_s;
    logic [2:0] sync_s;
    logic [2:0] wr_s;
    logic [2:0] load_outputs_n_s;
    logic [1:0] din_s;
    logic [1:0] cs_s;
    logic [1:0] sel_s;
    logic [1:0] chain_s;
    logic [1:0] rstp_s;
    logic [1:0] clr_s;
    logic [1:0] busy_s;
    logic [1:0][CMD_W-1:0] bus_s;
    dhw_cmd_t shreg;
    logic [4:0] bits;
    logic in_frame;
    logic serial_out;
    logic load_outputs_n_pend;
    logic grounded;
    logic busy_oe;
    logic busy_lvl;
    logic [NUM_CH-1:0][DATA_W-1:0] x1;
    logic [NUM_CH-1:0][DATA_W-1:0] offs;
    logic [NUM_CH-1:0][DATA_W-1:0] gain;
    logic [NUM_CH-1:0][DATA_W-1:0] x2;
    logic [NUM_CH-1:0][DATA_W-1:0] dac;
  } dhw_regs_t;

  dhw_regs_t r_q, r_d; // Registered state and its next value.
  dhw_cmd_if cq (); // Link to the command queue.
  logic sclk_rise, sclk_fall; // Serial clock edges.
  logic sync_fall, sync_rise; // Frame edges.
  logic wr_rise; // Parallel write strobe end.
  logic load_outputs_n_fall; // Load strobe assertion.

  // Register defaults of the channel store.
  function automatic dhw_regs_t set_defaults(input dhw_regs_t s);
    dhw_regs_t t;
    t = s;
    for (int i = 0; i < NUM_CH; i++) begin
      t.x1[i] = INPUT_DEF;
      t.offs[i] = OFFSET_DEF;
      t.gain[i] = GAIN_DEF;
      t.x2[i] = INPUT_DEF;
    end
    return t;
  endfunction

  // Whole reset value; sync chains of lines that idle high rest high, except the busy chain which rests low, so no false edge follows.
  function automatic dhw_regs_t reset_state();
    dhw_regs_t t;
    t = '0;
    t.st = ST_POR;
    t.sclk_s = '1;
    t.sync_s = '1;
    t.wr_s = '1;
    t.load_outputs_n_s = '1;
    t.cs_s = '1;
    t.rstp_s = '1;
    t.clr_s = '1;
    t.grounded = 1'b1;
    t.busy_oe = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      t.x1[i] = INPUT_DEF;
      t.offs[i] = OFFSET_DEF;
      t.gain[i] = GAIN_DEF;
      t.x2[i] = INPUT_DEF;
      t.dac[i] = INPUT_DEF;
    end
    return t;
  endfunction

  // Group mask in the upper nibble, register number in the lower one.
  function automatic logic chan_hit(input logic [ADDR_W-1:0] a, input logic [4:0] ch);
    logic [3:0] want;
    want = (ch[2:0] == 3'h6) ? 4'h8 : (ch[2:0] == 3'h7) ? 4'h9 : {1'b0, ch[2:0]};
    if (a[7:4] == 4'h0) begin
      chan_hit = 1'b1; // All channels; lower bits ignored.
    end else begin
      chan_hit = a[4 + ch[4:3]] & (a[3:0] == want);
    end
  endfunction

  // Increment or decrement with saturation instead of wrap.
  function automatic dhw_word_t step_value(input dhw_word_t v, input logic [STEP_W-1:0] amt,
                                           input logic up);
    logic [DATA_W:0] sum;
    sum = {1'b0, v} + {8'h00, amt};
    if (up) begin
      step_value = sum[DATA_W] ? FULL_SCALE : sum[DATA_W-1:0];
    end else begin
      step_value = (v < {7'h00, amt}) ? ZERO_SCALE : v - {7'h00, amt};
    end
  endfunction

  // Edges are taken from the second and third flops of each chain only.
  assign sclk_rise = r_q.sclk_s[1] & ~r_q.sclk_s[2];
  assign sclk_fall = ~r_q.sclk_s[1] & r_q.sclk_s[2];
  assign sync_fall = ~r_q.sync_s[1] & r_q.sync_s[2];
  assign sync_rise = r_q.sync_s[1] & ~r_q.sync_s[2];
  assign wr_rise = r_q.wr_s[1] & ~r_q.wr_s[2];
  assign load_outputs_n_fall = ~r_q.load_outputs_n_s[1] & r_q.load_outputs_n_s[2];

  // Command queue.
  dhw_cmd_fifo u_fifo (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .q(cq.queue)
  );

  // Next state: intake, execution, reset sequencing and output loading.
  always_comb begin
    logic ignore_load_outputs_n;
    logic [1:0] dest;
    dhw_word_t dw;
    ignore_load_outputs_n = 1'b0;
    dest = r_q.cur[CMD_DHI_BIT:CMD_DLO_BIT];
    dw = r_q.cur[DATA_W-1:0]; // Straight binary, bit 13 is the MSB.
    r_d = r_q;
    cq.push_valid = 1'b0;
    cq.push_data = r_q.shreg;
    cq.pop_ready = 1'b0;
    // Two flop synchronizers on every pin from outside the clock domain.
    r_d.sclk_s = {r_q.sclk_s[1:0], serial_clock_i};
    r_d.sync_s = {r_q.sync_s[1:0], frame_sync_n_i};
    r_d.wr_s = {r_q.wr_s[1:0], write_strobe_n_i};
    r_d.load_outputs_n_s = {r_q.load_outputs_n_s[1:0], load_outputs_n_i};
    r_d.din_s = {r_q.din_s[0], serial_in_i};
    r_d.cs_s = {r_q.cs_s[0], chip_select_n_i};
    r_d.sel_s = {r_q.sel_s[0], interface_select_i};
    r_d.chain_s = {r_q.chain_s[0], chain_enable_i};
    r_d.rstp_s = {r_q.rstp_s[0], reset_pin_n_i};
    r_d.clr_s = {r_q.clr_s[0], output_clear_n_i};
    r_d.busy_s = {r_q.busy_s[0], busy_i};
    r_d.bus_s = {r_q.bus_s[0], {dest_select_hi_i, dest_select_lo_i, channel_address_i,
                                data_word_i}};
    r_d.busy_lvl = 1'b0;

    // Command intake; nothing is taken while power-on runs.
    if (r_q.st != ST_POR) begin
      if (r_q.sel_s[1]) begin
        // Serial link selected, parallel bus ignored.
        if (r_q.chain_s[1]) begin
          // Chain mode: shift for as long as the frame is low.
          if (sync_fall) begin
            r_d.in_frame = 1'b1;
            r_d.bits = '0;
          end
          if (r_q.in_frame && !r_q.sync_s[1] && sclk_fall) begin
            r_d.shreg = {r_q.shreg[CMD_W-2:0], r_q.din_s[1]};
            if (r_q.bits != SER_BITS) begin
              r_d.bits = r_q.bits + 5'h01;
            end
          end
          // Oldest bit launched on the rising serial clock edge.
          if (r_q.in_frame && sclk_rise) begin
            r_d.serial_out = r_q.shreg[CMD_W-1];
          end
          // Frame end latches the last 24 bits, short frames are dropped.
          if (r_q.in_frame && sync_rise) begin
            r_d.in_frame = 1'b0;
            if (r_q.bits == SER_BITS) begin
              cq.push_valid = 1'b1;
              cq.push_data = r_q.shreg;
            end
          end
        end else begin
          // Standalone: a frame start is honoured only outside a frame.
          if (sync_fall && !r_q.in_frame) begin
            r_d.in_frame = 1'b1;
            r_d.bits = '0;
          end
          // Clock edges count whether the clock runs freely or in bursts.
          if (r_q.in_frame && sclk_fall) begin
            r_d.shreg = {r_q.shreg[CMD_W-2:0], r_q.din_s[1]};
            r_d.bits = r_q.bits + 5'h01;
            if (r_q.bits == SER_BITS - 5'h01) begin
              // Word complete; later clocks are ignored until a new frame.
              r_d.in_frame = 1'b0;
              cq.push_valid = 1'b1;
              cq.push_data = {r_q.shreg[CMD_W-2:0], r_q.din_s[1]};
            end
          end
        end
      end else if (wr_rise && !r_q.cs_s[1]) begin
        // Parallel write taken at the strobe's rising edge.
        cq.push_valid = 1'b1;
        cq.push_data = r_q.bus_s[1];
      end
    end

    // Sequencer.
    case (r_q.st)
      ST_POR: begin
        // Outputs forced to ground reference, busy held.
        r_d.grounded = 1'b1;
        ignore_load_outputs_n = 1'b1;
        if (r_q.cnt == CNT_W'(POR_CYCLES - 1)) begin
          r_d.st = ST_IDLE;
          r_d.cnt = '0;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      ST_RST: begin
        // Registers back to defaults for the whole sequence.
        r_d = set_defaults(r_d);
        r_d.grounded = 1'b1;
        if (!r_q.rstp_s[1]) begin
          r_d.cnt = '0;
        end else if (r_q.cnt == CNT_W'(RST_CYC - 1)) begin
          r_d.st = ST_IDLE;
          r_d.cnt = '0;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      ST_IDLE: begin
        if (cq.pop_valid) begin
          cq.pop_ready = 1'b1;
          r_d.cur = cq.pop_data;
          r_d.ch = '0;
          if (cq.pop_data[CMD_DHI_BIT:CMD_DLO_BIT] == DEST_SPECIAL &&
              cq.pop_data[DATA_W-1:0] == SOFT_RESET_CODE) begin
            r_d.st = ST_RST; // Soft reset.
            r_d.cnt = '0;
          end else begin
            r_d.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        // One channel per cycle; every addressed channel is written.
        if (chan_hit(r_q.cur[CMD_ADDR_LSB +: ADDR_W], r_q.ch)) begin
          case (dest)
            DEST_INPUT: begin
              r_d.x1[r_q.ch] = dw;
              r_d.x2[r_q.ch] = dw;
            end
            DEST_OFFSET: begin
              r_d.offs[r_q.ch] = dw;
              r_d.x2[r_q.ch] = r_q.x1[r_q.ch];
            end
            DEST_GAIN: begin
              r_d.gain[r_q.ch] = dw;
              r_d.x2[r_q.ch] = r_q.x1[r_q.ch];
            end
            default: begin
              // Special function: step by the amount in the low bits.
              r_d.x1[r_q.ch] = step_value(r_q.x1[r_q.ch], dw[STEP_W-1:0], dw[STEP_DIR_BIT]);
              r_d.x2[r_q.ch] = r_d.x1[r_q.ch];
            end
          endcase
        end
        r_d.ch = r_q.ch + 5'h01;
        if (r_q.ch == 5'h1f) begin
          r_d.st = ST_IDLE;
        end
      end
      default: begin
        r_d.st = ST_POR;
        r_d.cnt = '0;
      end
    endcase

    // Reset pin held low restarts the reset sequence and grounds outputs.
    if (!r_q.rstp_s[1] && r_q.st != ST_POR) begin
      r_d.st = ST_RST;
      r_d.cnt = '0;
      r_d.grounded = 1'b1;
      ignore_load_outputs_n = 1'b1;
    end

    // Hardware clear grounds outputs and masks the load strobe.
    if (!r_q.clr_s[1]) begin
      r_d.grounded = 1'b1;
      ignore_load_outputs_n = 1'b1;
    end

    // Busy held while sequencing, executing or with work queued.
    r_d.busy_oe = (r_d.st != ST_IDLE) | cq.pop_valid;

    // Load strobe: remembered while busy, applied once the shared line is high.
    if (ignore_load_outputs_n) begin
      r_d.load_outputs_n_pend = 1'b0;
    end else begin
      if (load_outputs_n_fall) begin
        r_d.load_outputs_n_pend = 1'b1;
      end
      if ((r_q.load_outputs_n_pend || !r_q.load_outputs_n_s[1]) && r_q.busy_s[1] && !r_q.busy_oe) begin
        // Outputs change only here, so power-on values hold until then.
        r_d.dac = r_q.x2;
        r_d.load_outputs_n_pend = 1'b0;
        r_d.grounded = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      r_q <= reset_state();
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flops; the busy pin only ever pulls low.
  assign busy_o = r_q.busy_lvl;
  assign busy_oe_o = r_q.busy_oe;
  assign serial_out_o = r_q.serial_out;
  assign outputs_grounded_o = r_q.grounded;
  assign dac_value_o = r_q.dac;
endmodule
`default_nettype wire

// *** verif/dhw_top_props.sv ***
// Port level checks of the DAC write control top.
`timescale 1ns/10ps
`default_nettype none
module dhw_top_props
  import dhw_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC
) (
  // Clock, resets and control.
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic reset_pin_n_i,
  input wire logic interface_select_i,
  // Busy line.
  input wire logic busy_i,
  input wire logic busy_o,
  input wire logic busy_oe_o,
  // Parallel and serial inputs.
  input wire logic chip_select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic frame_sync_n_i,
  input wire logic chain_enable_i,
  // Outputs.
  input wire logic serial_out_o,
  input wire logic outputs_grounded_o,
  input wire logic [NUM_CH-1:0][DATA_W-1:0] dac_value_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Length of the current busy run, saturating so long runs never wrap.
  logic [11:0] run_q;
  // Counts cycles while this device pulls busy low.
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      run_q <= 12'h0;
    end else begin
      run_q <= busy_oe_o ? run_q + {11'h0, ~&run_q} : 12'h0;
    end
  end
  a_por_state: assert property ($rose(reset_n_i) |-> busy_oe_o && outputs_grounded_o
    && dac_value_o == '0) else $error("power-on state wrong");
  a_por_busy_hold: assert property ($rose(reset_n_i) |-> busy_oe_o [*8])
    else $error("busy released early after power-on");
  a_busy_pull_low: assert property (busy_oe_o |-> !busy_o)
    else $error("busy driven high");
  a_update_gate: assert property ($changed(dac_value_o) |-> !$past(busy_oe_o)
    && $past(busy_i)) else $error("outputs updated while busy");
  a_pin_grounds: assert property (!reset_pin_n_i [*5] |-> outputs_grounded_o
    && busy_oe_o) else $error("reset pin did not ground outputs");
  a_write_busy: assert property ((!chip_select_n_i && !interface_select_i) [*4]
    ##1 ($rose(write_strobe_n_i) && !chip_select_n_i && !busy_oe_o && reset_pin_n_i)
    |-> ##[1:8] busy_oe_o) else $error("write did not raise busy");
  a_busy_span: assert property ($fell(busy_oe_o) |-> int'(run_q) >=
    (POR_CYCLES < 32 ? POR_CYCLES : 32)) else $error("busy run too short");
  a_chain_only: assert property ($changed(serial_out_o) |-> chain_enable_i)
    else $error("serial out moved outside chain mode");
endmodule
bind dhw_top dhw_top_props #(.POR_CYCLES(POR_CYCLES)) u_props (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reset_pin_n_i(reset_pin_n_i),
  .interface_select_i(interface_select_i), .busy_i(busy_i), .busy_o(busy_o),
  .busy_oe_o(busy_oe_o), .chip_select_n_i(chip_select_n_i),
  .write_strobe_n_i(write_strobe_n_i), .frame_sync_n_i(frame_sync_n_i),
  .chain_enable_i(chain_enable_i), .serial_out_o(serial_out_o),
  .outputs_grounded_o(outputs_grounded_o), .dac_value_o(dac_value_o));
`default_nettype wire

// *** verif/dhw_host_model.sv ***
// Host controller model issuing parallel writes and serial frames.
`timescale 1ns/10ps
`default_nettype none
module dhw_host_model
  import dhw_pkg::*;
(
  // Clock.
  input wire logic mclk_i,
  // Parallel bus, packed as select pair, address, data.
  output logic cs_n_o,
  output logic wr_n_o,
  output logic [23:0] bus_o,
  // Serial link.
  output logic sclk_o,
  output logic fs_n_o,
  output logic sdin_o,
  input wire logic sdo_i
);
  logic [23:0] so_w; // Chain output gathered after the first 24 clocks.
  // Idle levels: link clock stands high outside frames.
  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    bus_o = 24'h0;
    sclk_o = 1'b1;
    fs_n_o = 1'b1;
    sdin_o = 1'b0;
    so_w = 24'h0;
  end
  // One strobe carries one command; the bus is scrambled once its hold ends.
  task automatic par_write(input dhw_cmd_t c);
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    bus_o <= c;
    wr_n_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
    wr_n_o <= 1'b1;
    repeat (2) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    bus_o <= ~c;
    repeat (3) @(posedge mclk_i);
  endtask
  // Burst frame of n bits, MSB first; data set on the rise, taken on the fall.
  task automatic ser_frame(input logic [47:0] w, input int n);
    @(posedge mclk_i);
    fs_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdin_o <= w[n-1-i];
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b1;
      // The bit launched on the previous rise is still standing here.
      if (i >= 24) begin
        so_w <= {so_w[22:0], sdo_i};
      end
    end
    repeat (4) @(posedge mclk_i);
    fs_n_o <= 1'b1;
    sdin_o <= ~sdin_o;
    repeat (8) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// *** verif/dhw_top_tb.sv ***
// Self-checking bench for the DAC write control top.
`timescale 1ns/10ps
`default_nettype none
module dhw_top_tb;
  import dhw_pkg::*;
  logic clk, rst_n, pin_n, clr_n, ld_n, sel, hold, chain, busy_w;
  logic busy_o, busy_oe, cs_n, wr_n, sclk, fs_n, sdin, serial_out, gnd;
  logic [23:0] bus;
  logic [NUM_CH-1:0][DATA_W-1:0] dac;
  int failures, cmp_count;
  // Write table: command, channel to read back, expected code.
  dhw_cmd_t wr_t [11] = '{{DEST_INPUT, 8'h10, 14'h1234}, {DEST_OFFSET, 8'h10, 14'h0abc},
    {DEST_GAIN, 8'h10, 14'h0001}, {DEST_SPECIAL, 8'h10, 14'h017f},
    {DEST_INPUT, 8'h11, 14'h3fc0}, {DEST_SPECIAL, 8'h11, 14'h017f},
    {DEST_SPECIAL, 8'h11, 14'h0005}, {DEST_INPUT, 8'h12, 14'h0010},
    {DEST_SPECIAL, 8'h12, 14'h007f}, {DEST_INPUT, 8'h38, 14'h2a5a},
    {DEST_INPUT, 8'h00, 14'h0777}};
  int ch_t [11] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 14, 31};
  dhw_word_t ex_t [11] = '{14'h1234, 14'h1234, 14'h1234, 14'h12b3, 14'h3fc0, 14'h3fff,
    14'h3ffa, 14'h0010, 14'h0000, 14'h2a5a, 14'h0777};
  // Open-drain busy wire with its pull-up, shared with another holder.
  assign busy_w = !(busy_oe || hold);
  always #25 clk = ~clk;
  dhw_top #(.POR_CYCLES(40)) u_dut (.mclk_i(clk), .reset_n_i(rst_n), .reset_pin_n_i(pin_n),
    .output_clear_n_i(clr_n), .load_outputs_n_i(ld_n), .interface_select_i(sel),
    .busy_i(busy_w), .busy_o(busy_o), .busy_oe_o(busy_oe), .chip_select_n_i(cs_n),
    .write_strobe_n_i(wr_n), .dest_select_hi_i(bus[23]), .dest_select_lo_i(bus[22]),
    .channel_address_i(bus[21:14]), .data_word_i(bus[13:0]), .serial_clock_i(sclk),
    .frame_sync_n_i(fs_n), .serial_in_i(sdin), .chain_enable_i(chain),
    .serial_out_o(serial_out), .outputs_grounded_o(gnd), .dac_value_o(dac));
  dhw_host_model u_host (.mclk_i(clk), .cs_n_o(cs_n), .wr_n_o(wr_n), .bus_o(bus),
    .sclk_o(sclk), .fs_n_o(fs_n), .sdin_o(sdin), .sdo_i(serial_out));
  // Compares after the edge's updates have landed.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    #1;
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pulses the load strobe.
  task automatic pulse_ld();
    @(posedge clk);
    ld_n <= 1'b0;
    repeat (4) @(posedge clk);
    ld_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // Waits, bounded, until the device lets busy go.
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (4) @(posedge clk);
    while (busy_oe !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) failures++;
  endtask
  task automatic print_verdict();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    {clk, rst_n, sel, hold, chain, failures, cmp_count} = '0;
    {pin_n, clr_n, ld_n} = 3'h7;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(24'(busy_oe), 24'h1);
    pulse_ld();
    u_host.par_write({DEST_INPUT, 8'h10, 14'h0155});
    wait_idle();
    chk(24'(gnd), 24'h1);
    pulse_ld();
    chk(24'(gnd), 24'h0);
    chk(24'(dac[0]), 24'h0);
    // Each write alone, then load and read the addressed channel back.
    for (int i = 0; i < 11; i++) begin
      u_host.par_write(wr_t[i]);
      wait_idle();
      pulse_ld();
      chk(24'(dac[ch_t[i]]), 24'(ex_t[i]));
    end
    @(posedge clk);
    hold <= 1'b1;
    u_host.par_write({DEST_INPUT, 8'h10, 14'h0100});
    wait_idle();
    pulse_ld();
    chk(24'(dac[0]), 24'h0777);
    @(posedge clk);
    hold <= 1'b0;
    repeat (8) @(posedge clk);
    chk(24'(dac[0]), 24'h0100);
    @(posedge clk);
    sel <= 1'b1;
    u_host.par_write({DEST_INPUT, 8'h13, 14'h0222});
    u_host.ser_frame({20'h0, DEST_INPUT, 8'h13, 14'h0333, 4'hb}, 28);
    wait_idle();
    pulse_ld();
    chk(24'(dac[3]), 24'h0333);
    @(posedge clk);
    chain <= 1'b1;
    u_host.ser_frame({DEST_INPUT, 8'h14, 14'h0444, DEST_INPUT, 8'h15, 14'h0555}, 48);
    chk(u_host.so_w, {DEST_INPUT, 8'h14, 14'h0444});
    wait_idle();
    pulse_ld();
    chk(24'(dac[5]), 24'h0555);
    chk(24'(dac[4]), 24'h0777);
    u_host.ser_frame({24'h0, DEST_INPUT, 8'h15, 14'h0666}, 20);
    wait_idle();
    pulse_ld();
    chk(24'(dac[5]), 24'h0555);
    @(posedge clk);
    chain <= 1'b0;
    sel <= 1'b0;
    u_host.par_write({DEST_SPECIAL, 8'h00, 14'h3fff});
    repeat (1300) @(posedge clk);
    chk(24'(busy_oe), 24'h1);
    wait_idle();
    pulse_ld();
    chk(24'(dac[31]), 24'h0);
    u_host.par_write({DEST_INPUT, 8'h10, 14'h0123});
    wait_idle();
    pulse_ld();
    @(posedge clk);
    pin_n <= 1'b0;
    pulse_ld();
    chk(24'(gnd), 24'h1);
    @(posedge clk);
    pin_n <= 1'b1;
    wait_idle();
    chk(24'(gnd), 24'h1);
    pulse_ld();
    chk(24'(dac[0]), 24'h0);
    chk(24'(gnd), 24'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
